/* core/dbg_cfg.svh */
// Constants for the breakpoint, trigger and trace block.
// Assumes inclusion by bare name from core sources only.
`ifndef DBG_CFG_SVH
`define DBG_CFG_SVH

// Breakpoint register indices.
`define DBG_IDX_ADDR      4'h0
`define DBG_IDX_ADDR_MASK 4'h1
`define DBG_IDX_DATA      4'h2
`define DBG_IDX_DATA_MASK 4'h3
`define DBG_IDX_PC0       4'h4
`define DBG_IDX_PC_MASK   4'h8
`define DBG_NUM_REGS      9
`define DBG_NUM_PC        4

// Status code shown while halted.
`define DBG_PST_HALTED    4'hF

// Serial frame: write flag, 4-bit index, 32-bit data, MSB first.
`define DBG_FRAME_BITS    6'h25
`define DBG_FRAME_LAST    6'h24
`define DBG_FRAME_WR_BIT  36
`define DBG_FRAME_IDX_HI  35
`define DBG_FRAME_IDX_LO  32

// Condition select bits.
`define DBG_SEL_ADDR      0
`define DBG_SEL_DATA      1
`define DBG_SEL_PC        2

`endif

/* core/dbg_pkg.sv */
// Types shared by the breakpoint, trigger and trace block.
// Assumes nothing of its surroundings.
package dbg_pkg;
  typedef logic [3:0]  reg_index_t;
  typedef logic [31:0] word_t;
  typedef logic [2:0]  cond_sel_t;

  typedef enum logic [1:0]
  {
    ST_LEVEL1    = 2'b00,
    ST_LEVEL2    = 2'b01,
    ST_HALTED    = 2'b10,
    ST_DEBUG_INT = 2'b11
  } trig_state_t;
endpackage

/* core/serial_debug_link.sv */
// Serial debug channel: shifts frames in on the rising edge of the
// tool's clock and answers on its falling edges.
// Assumes the tool's clock is much slower than clk.
`timescale 1ns/1ns
`default_nettype none
`include "dbg_cfg.svh"

module serial_debug_link
(
  input  wire logic              clk,                // CPU clock
  input  wire logic              rst,                // Sync reset, high
  input  wire logic              serial_debug_clock, // Tool clock pin
  input  wire logic              serial_debug_in,    // Tool data pin
  output logic                   serial_debug_out,   // Data to tool
  output logic                   req_valid,          // Frame complete
  output logic                   req_write,          // Frame is a write
  output dbg_pkg::reg_index_t    req_index,          // Register index
  output dbg_pkg::word_t         req_wdata,          // Write data
  input  wire dbg_pkg::word_t    rsp_rdata           // Read data of index
);
  import dbg_pkg::*;

  logic [1:0]  clk_sync;
  logic [1:0]  din_sync;
  logic        clk_prev;
  logic [5:0]  bit_count;
  logic [36:0] shift_in;
  word_t       shift_out;
  logic        frame_done;

  wire rise_edge = clk_sync[1] & ~clk_prev;
  wire fall_edge = ~clk_sync[1] & clk_prev;
  wire last_bit  = rise_edge && (bit_count == `DBG_FRAME_LAST);
  wire [36:0] next_shift_in = {shift_in[35:0], din_sync[1]};

  // ==========================================================
  // Pin synchronisers and edge detection.
  always_ff @(posedge clk)
  begin
    clk_sync <= rst ? 2'h0 : {clk_sync[0], serial_debug_clock};
    din_sync <= rst ? 2'h0 : {din_sync[0], serial_debug_in};
    clk_prev <= rst ? 1'b0 : clk_sync[1];
  end

  // ==========================================================
  // Frame shifter.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bit_count <= 6'h00;
      shift_in  <= 37'h0;
    end
    else if (rise_edge)
    begin
      shift_in  <= next_shift_in;
      bit_count <= last_bit ? 6'h00 : bit_count + 6'h01;
    end
  end

  always_ff @(posedge clk)
    frame_done <= rst ? 1'b0 : last_bit;

  assign req_valid = frame_done;
  assign req_write = shift_in[`DBG_FRAME_WR_BIT];
  assign req_index = shift_in[`DBG_FRAME_IDX_HI:`DBG_FRAME_IDX_LO];
  assign req_wdata = shift_in[31:0];

  // ==========================================================
  // Answer path. The word read by a frame goes out during the next one,
  // so the tool always sees the answer one frame late. The falling edge
  // that closes a frame comes after the load and would throw the top bit
  // away, so only falling edges inside a frame shift.
  always_ff @(posedge clk)
  begin
    if (rst)
      shift_out <= 32'h0;
    else if (frame_done)
      shift_out <= rsp_rdata;
    else if (fall_edge && bit_count != 6'h00)
      shift_out <= {shift_out[30:0], 1'b0};
  end

  always_ff @(posedge clk)
    serial_debug_out <= rst ? 1'b0 : shift_out[31];
endmodule
`default_nettype wire

/* core/breakpoint_trigger_trace_port.sv */
// Breakpoint registers, trigger sequencer and trace port of the
// processor debug block.
// Assumes core inputs are on clk; serial pins arrive from outside.
`timescale 1ns/1ns
`default_nettype none
`include "dbg_cfg.svh"

module breakpoint_trigger_trace_port
#(
  parameter bit TRACE_PRESENT = 1'b1 // Full trace port fitted
)
(
  input  wire logic              clk,                 // CPU clock
  input  wire logic              rst,                 // Sync reset, high
  input  wire logic              serial_debug_clock,  // Tool clock pin
  input  wire logic              serial_debug_in,     // Tool data pin
  output logic                   serial_debug_out,    // Data to tool
  input  wire logic              cpu_sel,             // CPU register access
  input  wire logic              cpu_write,           // Access is a write
  input  wire logic              cpu_supervisor,      // CPU in supervisor
  input  wire dbg_pkg::reg_index_t cpu_index,         // Register index
  input  wire dbg_pkg::word_t    cpu_wdata,           // Write data
  output dbg_pkg::word_t         cpu_rdata,           // Read data
  input  wire logic              trigger_enable,      // Arm trigger logic
  input  wire logic              cfg_dual_level,      // Two-level trigger
  input  wire logic              cfg_action_halt,     // 1 halt, 0 interrupt
  input  wire dbg_pkg::cond_sel_t level1_sel,         // Level one terms
  input  wire dbg_pkg::cond_sel_t level2_sel,         // Level two terms
  input  wire logic              bus_valid,           // Operand cycle valid
  input  wire dbg_pkg::word_t    bus_addr,            // Operand address
  input  wire dbg_pkg::word_t    bus_data,            // Operand data
  input  wire logic              pc_valid,            // Instruction valid
  input  wire dbg_pkg::word_t    pc_value,            // Instruction address
  input  wire logic              resume,              // Leave halt
  input  wire logic              debug_int_done,      // Handler finished
  input  wire logic              irq_pending,         // Interrupt waiting
  input  wire logic [2:0]        irq_level,           // Its priority
  input  wire logic [2:0]        irq_critical_level,  // Critical threshold
  input  wire logic [3:0]        core_status,         // Core status code
  input  wire logic [3:0]        core_trace_data,     // Core trace nibble
  output logic                   halt_request,        // Stop the core
  output logic                   debug_int_request,   // Debug exception
  output logic                   irq_allowed,         // Core may take irq
  output logic [3:0]             processor_status,    // Status trace bus
  output logic [3:0]             debug_data_trace,    // Data trace bus
  output logic                   trace_clock_out,     // Trace clock
  output logic                   combined_status_halt // All status ones
);
  import dbg_pkg::*;

  function automatic logic masked_match(input word_t value,
                                        input word_t ref_value,
                                        input word_t mask);
    masked_match = ((value ^ ref_value) & ~mask) == 32'h0;
  endfunction

  function automatic logic level_hit(input cond_sel_t sel,
                                     input logic addr_ok,
                                     input logic data_ok,
                                     input logic pc_ok);
    level_hit = (sel != 3'h0)
              && (!sel[`DBG_SEL_ADDR] || addr_ok)
              && (!sel[`DBG_SEL_DATA] || data_ok)
              && (!sel[`DBG_SEL_PC]   || pc_ok);
  endfunction

  // ==========================================================
  // Breakpoint register file.
  word_t       bkpt [`DBG_NUM_REGS];
  logic        link_valid;
  logic        link_write;
  reg_index_t  link_index;
  word_t       link_wdata;
  word_t       link_rdata;
  trig_state_t state;
  trig_state_t next_state;
  logic [3:0]  status_reg;

  serial_debug_link link
  (
    .clk                (clk),
    .rst                (rst),
    .serial_debug_clock (serial_debug_clock),
    .serial_debug_in    (serial_debug_in),
    .serial_debug_out   (serial_debug_out),
    .req_valid          (link_valid),
    .req_write          (link_write),
    .req_index          (link_index),
    .req_wdata          (link_wdata),
    .rsp_rdata          (link_rdata)
  );

  // Supervisor-only access; user-mode accesses are ignored.
  wire cpu_ok  = cpu_sel && cpu_supervisor;
  wire link_wr = link_valid && link_write;
  wire cpu_wr  = cpu_ok && cpu_write;

  // The serial channel wins when both write in one cycle, so the tool's
  // setup cannot be lost to a running program.
  wire        any_wr   = link_wr || cpu_wr;
  wire [3:0]  wr_index = link_wr ? link_index : cpu_index;
  wire word_t wr_data  = link_wr ? link_wdata : cpu_wdata;

  assign link_rdata = (link_index < `DBG_NUM_REGS) ? bkpt[link_index]
                                                   : 32'h0;
  wire word_t cpu_read = (cpu_index < `DBG_NUM_REGS) ? bkpt[cpu_index]
                                                     : 32'h0;

  genvar gi;
  generate
    for (gi = 0; gi < `DBG_NUM_REGS; gi++)
    begin : g_reg
      always_ff @(posedge clk)
      begin
        if (rst)
          bkpt[gi] <= 32'h0;
        else if (any_wr && wr_index == 4'(gi))
          bkpt[gi] <= wr_data;
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (rst)
      cpu_rdata <= 32'h0;
    else if (cpu_ok && !cpu_write)
      cpu_rdata <= cpu_read;
  end

  // ==========================================================
  // Comparators.
  wire addr_ok = bus_valid && masked_match(bus_addr, bkpt[`DBG_IDX_ADDR],
                                           bkpt[`DBG_IDX_ADDR_MASK]);
  wire data_ok = bus_valid && masked_match(bus_data, bkpt[`DBG_IDX_DATA],
                                           bkpt[`DBG_IDX_DATA_MASK]);
  logic [`DBG_NUM_PC-1:0] pc_hits;

  generate
    for (gi = 0; gi < `DBG_NUM_PC; gi++)
    begin : g_pc
      assign pc_hits[gi] = masked_match(pc_value,
                                        bkpt[`DBG_IDX_PC0 + gi],
                                        bkpt[`DBG_IDX_PC_MASK]);
    end
  endgenerate

  wire pc_ok = pc_valid && (pc_hits != '0);

  wire hit1 = level_hit(level1_sel, addr_ok, data_ok, pc_ok);
  wire hit2 = level_hit(level2_sel, addr_ok, data_ok, pc_ok);

  // ==========================================================
  // Trigger sequencer.
  wire fire = trigger_enable
            && ((state == ST_LEVEL1 && hit1 && !cfg_dual_level)
             || (state == ST_LEVEL2 && hit2));
  wire fire_state_halt = cfg_action_halt;

  always_comb
  begin
    next_state = state;
    case (state)
      ST_LEVEL1:
        if (fire)
          next_state = fire_state_halt ? ST_HALTED : ST_DEBUG_INT;
        else if (trigger_enable && cfg_dual_level && hit1)
          next_state = ST_LEVEL2;
      ST_LEVEL2:
        if (!trigger_enable)
          next_state = ST_LEVEL1;
        else if (fire)
          next_state = fire_state_halt ? ST_HALTED : ST_DEBUG_INT;
      ST_HALTED:
        if (resume)
          next_state = ST_LEVEL1;
      ST_DEBUG_INT:
        if (debug_int_done)
          next_state = ST_LEVEL1;
      default:
        next_state = ST_LEVEL1;
    endcase
  end

  always_ff @(posedge clk)
    state <= rst ? ST_LEVEL1 : next_state;

  assign halt_request = (state == ST_HALTED);

  // One-cycle request as the sequencer enters the interrupt state.
  always_ff @(posedge clk)
    debug_int_request <= !rst && fire && !fire_state_halt;

  // Only interrupts at or above the critical level get through while the
  // debug handler runs; a halted core takes none.
  assign irq_allowed = irq_pending
                     && (state != ST_HALTED)
                     && (state != ST_DEBUG_INT
                         || irq_level >= irq_critical_level);

  // ==========================================================
  // Trace port.
  wire [3:0] next_status = (next_state == ST_HALTED) ? `DBG_PST_HALTED
                                                     : core_status;

  always_ff @(posedge clk)
    status_reg <= rst ? 4'h0 : next_status;

  assign combined_status_halt = &status_reg;

  // The trace clock toggles once per CPU cycle, so each of its edges
  // marks one CPU cycle of trace data.
  generate
    if (TRACE_PRESENT)
    begin : g_trace
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          processor_status <= 4'h0;
          debug_data_trace <= 4'h0;
          trace_clock_out  <= 1'b0;
        end
        else
        begin
          processor_status <= next_status;
          debug_data_trace <= core_trace_data;
          trace_clock_out  <= ~trace_clock_out;
        end
      end
    end
    else
    begin : g_no_trace
      assign processor_status = 4'h0;
      assign debug_data_trace = 4'h0;
      assign trace_clock_out  = 1'b0;
    end
  endgenerate
endmodule
`default_nettype wire

/* tb/dbg_checker_asserts.sv */
// Checker for the debug block: trigger, halt, trace and access timing.
// Assumes it is bound to the block and sees only the block's ports.
`timescale 1ns/1ns
`default_nettype none

module dbg_checker
#(
  parameter bit TRACE_PRESENT = 1'b1 // Full trace port fitted
)
(
  input wire logic           clk,                 // CPU clock
  input wire logic           rst,                 // Sync reset, high
  input wire logic           cpu_sel,             // CPU access strobe
  input wire logic           cpu_write,           // Access is a write
  input wire logic           cpu_supervisor,      // Supervisor mode
  input wire dbg_pkg::word_t cpu_rdata,           // Read data
  input wire logic           trigger_enable,      // Trigger armed
  input wire logic           cfg_action_halt,     // Halt or interrupt
  input wire logic           resume,              // Leave halt
  input wire logic           debug_int_done,      // Handler finished
  input wire logic           irq_pending,         // Interrupt waiting
  input wire logic [2:0]     irq_level,           // Its priority
  input wire logic [2:0]     irq_critical_level,  // Critical threshold
  input wire logic [3:0]     core_trace_data,     // Core trace nibble
  input wire logic           halt_request,        // Stop the core
  input wire logic           debug_int_request,   // Debug exception
  input wire logic           irq_allowed,         // Core may take irq
  input wire logic [3:0]     processor_status,    // Status trace bus
  input wire logic [3:0]     debug_data_trace,    // Data trace bus
  input wire logic           trace_clock_out,     // Trace clock
  input wire logic           combined_status_halt // All status ones
);
  // The interrupt state has no port of its own, so it is rebuilt here.
  logic in_dbg;

  always_ff @(posedge clk)
    if (rst || debug_int_done)
      in_dbg <= 1'b0;
    else if (debug_int_request)
      in_dbg <= 1'b1;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Assertions
  combined_and_a: assert property (!TRACE_PRESENT ||
    combined_status_halt == (&processor_status))
    else $error("combined halt differs from status AND");
  halt_status_a: assert property (halt_request |->
    processor_status == 4'hF)
    else $error("halted without all-ones status");
  int_pulse_a: assert property (debug_int_request |=>
    !debug_int_request) else $error("debug interrupt pulse too long");
  halt_cause_a: assert property ($rose(halt_request) |->
    $past(trigger_enable && cfg_action_halt))
    else $error("halt without armed halt action");
  int_cause_a: assert property (debug_int_request |->
    $past(trigger_enable && !cfg_action_halt) && !halt_request)
    else $error("debug interrupt without interrupt action");
  halt_hold_a: assert property (halt_request |=>
    halt_request == !$past(resume))
    else $error("halt not held until resume");
  irq_halt_a: assert property (halt_request |-> !irq_allowed)
    else $error("interrupt allowed while halted");
  irq_crit_a: assert property (in_dbg && irq_pending |->
    irq_allowed == (irq_level >= irq_critical_level))
    else $error("critical interrupt filter wrong");
  trace_data_a: assert property (!$past(rst) |->
    debug_data_trace == $past(core_trace_data))
    else $error("data trace not one cycle behind");
  trace_clk_a: assert property (!$past(rst) && !$past(rst, 2) |->
    trace_clock_out != $past(trace_clock_out))
    else $error("trace clock did not toggle");
  rdata_hold_a: assert property (!(cpu_sel && cpu_supervisor &&
    !cpu_write) |=> $stable(cpu_rdata))
    else $error("read data changed without a read");

  halt_seen_c: cover property ($rose(halt_request));
  int_seen_c: cover property (debug_int_request);
  crit_irq_c: cover property (in_dbg && irq_allowed);
endmodule

`default_nettype wire

/* tb/serial_tool.sv */
// Model of the debug tool on the serial channel: 37-bit frames.
// Assumes the block's clock is far faster than the 800 ns tool clock.
`timescale 1ns/1ns
`default_nettype none

module serial_tool
(
  output logic      serial_debug_clock, // Tool clock, low between frames
  output logic      serial_debug_in,    // Tool data
  input  wire logic serial_debug_out    // Answer from the block
);
  initial
  begin
    serial_debug_clock = 1'b0;
    serial_debug_in    = 1'b0;
  end

  // Sends one frame MSB first and returns the word answered during it,
  // which belongs to the frame before. Answer bits are taken at the end
  // of the first 32 high phases, well clear of the block's shift delay.
  task automatic frame(input logic wr, input logic [3:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd);
    logic [36:0] sh;
    sh = {wr, idx, wd};
    rd = 32'h0;
    for (int i = 36; i >= 0; i--)
    begin
      serial_debug_in = sh[i];
      #400 serial_debug_clock = 1'b1;
      #400 rd = (i > 4) ? {rd[30:0], serial_debug_out} : rd;
      serial_debug_clock = 1'b0;
    end
    // A released data line must not look like the last bit.
    serial_debug_in = ~sh[0];
    #800;
  endtask
endmodule

`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the breakpoint, trigger and trace block.
// Assumes the design sources and the serial tool model are compiled.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import dbg_pkg::*;
  logic       clk, rst, serial_debug_clock, serial_debug_in;
  logic       serial_debug_out, cpu_sel, cpu_write, cpu_supervisor;
  reg_index_t cpu_index;
  word_t      cpu_wdata, cpu_rdata, bus_addr, bus_data, pc_value;
  logic       trigger_enable, cfg_dual_level, cfg_action_halt;
  cond_sel_t  level1_sel, level2_sel;
  logic       bus_valid, pc_valid, resume, debug_int_done, irq_pending;
  logic [2:0] irq_level, irq_critical_level;
  logic [3:0] core_status, core_trace_data, processor_status;
  logic [3:0] debug_data_trace;
  logic       halt_request, debug_int_request, irq_allowed;
  logic       trace_clock_out, combined_status_halt;
  int         bad_count, checks;
  word_t      seed, w, rd, m;
  word_t      regs [9];

  breakpoint_trigger_trace_port #(.TRACE_PRESENT(1'b1)) dut_u (.clk,
    .rst, .serial_debug_clock, .serial_debug_in, .serial_debug_out,
    .cpu_sel, .cpu_write, .cpu_supervisor, .cpu_index, .cpu_wdata,
    .cpu_rdata, .trigger_enable, .cfg_dual_level, .cfg_action_halt,
    .level1_sel, .level2_sel, .bus_valid, .bus_addr, .bus_data,
    .pc_valid, .pc_value, .resume, .debug_int_done, .irq_pending,
    .irq_level, .irq_critical_level, .core_status, .core_trace_data,
    .halt_request, .debug_int_request, .irq_allowed, .processor_status,
    .debug_data_trace, .trace_clock_out, .combined_status_halt);

  serial_tool tool_u (.serial_debug_clock, .serial_debug_in,
    .serial_debug_out);

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Trace nibbles walk a full-period sequence without touching the seed.
  initial
  begin
    {core_status, core_trace_data} = 8'h00;
    forever @(negedge clk)
      {core_status, core_trace_data} <= {core_status, core_trace_data}
        * 8'h05 + 8'h03;
  end

  function automatic word_t rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string name, input word_t exp, input word_t got);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Strobe is left up so back-to-back calls keep it high with no idle cycle between them.
  task automatic cpu(input logic wr, input logic sup, input logic [3:0] idx,
                     input word_t wd);
    {cpu_sel, cpu_write, cpu_supervisor, cpu_index} = {1'b1, wr, sup, idx};
    cpu_wdata = wd;
    @(negedge clk);
  endtask

  task automatic step(input logic bv, input word_t a, input word_t d,
                      input logic pv, input word_t pc);
    {bus_valid, bus_addr, bus_data, pc_valid, pc_value} = {bv, a, d, pv, pc};
    @(negedge clk);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #3000000;
    bad_count++;
    print_verdict();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    seed = 32'h529BF2F6;
    {rst, cpu_sel, cpu_write, cpu_supervisor, cpu_index} = 8'h80;
    {cpu_wdata, bus_addr, bus_data, pc_value} = '0;
    {trigger_enable, cfg_dual_level, cfg_action_halt} = 3'h0;
    {level1_sel, level2_sel, bus_valid, pc_valid} = 8'h00;
    {resume, debug_int_done, irq_pending} = 3'h0;
    {irq_level, irq_critical_level} = 6'h00;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    for (int i = 0; i < 9; i++)
    begin
      regs[i] = rnd();
      cpu(1'b1, 1'b1, i[3:0], regs[i]);
    end
    cpu(1'b1, 1'b0, 4'h0, ~regs[0]);
    cpu(1'b1, 1'b1, 4'hC, rnd());
    for (int i = 0; i < 16; i++)
    begin
      cpu(1'b0, 1'b1, i[3:0], 32'h0);
      chk("cpu_rdata", (i < 9) ? regs[i % 9] : 32'h0, cpu_rdata);
    end
    cpu_sel = 1'b0;
    w = rnd();
    tool_u.frame(1'b1, 4'h2, w, rd);
    tool_u.frame(1'b0, 4'h2, 32'h0, rd);
    chk("serial_debug_out", regs[2], rd);
    tool_u.frame(1'b0, 4'h5, 32'h0, rd);
    chk("serial_debug_out", w, rd);
    @(negedge clk);
    chk("debug_data_trace", core_trace_data, debug_data_trace);
    cpu(1'b0, 1'b1, 4'h2, 32'h0);
    chk("cpu_rdata", w, cpu_rdata);
    m = rnd() & 32'hFFFF_EFFF;
    cpu(1'b1, 1'b1, 4'h1, m);
    cpu(1'b1, 1'b1, 4'h3, 32'h0);
    cpu_sel = 1'b0;
    {trigger_enable, cfg_action_halt, level1_sel} = 5'b11_001;
    step(1'b1, regs[0] ^ 32'h0000_1000, 32'h0, 1'b0, 32'h0);
    chk("halt_request", 32'h0, halt_request);
    step(1'b1, regs[0] ^ (m & rnd()), 32'h0, 1'b0, 32'h0);
    chk("halt_request", 32'h1, halt_request);
    chk("processor_status", 32'hF, processor_status);
    chk("combined_status_halt", 32'h1, combined_status_halt);
    step(1'b0, 32'h0, 32'h0, 1'b0, 32'h0);
    resume = 1'b1;
    @(negedge clk);
    resume = 1'b0;
    chk("halt_request", 32'h0, halt_request);
    {cfg_dual_level, cfg_action_halt, level1_sel, level2_sel} = 8'b10_100_010;
    step(1'b1, 32'h0, w, 1'b0, 32'h0);
    chk("debug_int_request", 32'h0, debug_int_request);
    step(1'b0, 32'h0, 32'h0, 1'b1, regs[6]);
    chk("debug_int_request", 32'h0, debug_int_request);
    step(1'b1, 32'h0, w, 1'b0, 32'h0);
    chk("debug_int_request", 32'h1, debug_int_request);
    step(1'b0, 32'h0, 32'h0, 1'b0, 32'h0);
    chk("debug_int_request", 32'h0, debug_int_request);
    {irq_pending, irq_critical_level} = 4'b1_101;
    for (int lv = 0; lv < 8; lv++)
    begin
      irq_level = lv[2:0];
      m = trace_clock_out;
      #10 chk("irq_allowed", {31'h0, lv >= 5}, irq_allowed);
      @(negedge clk);
      chk("trace_clock_out", m ^ 32'h1, trace_clock_out);
    end
    debug_int_done = 1'b1;
    @(negedge clk);
    debug_int_done = 1'b0;
    print_verdict();
  end
endmodule

bind breakpoint_trigger_trace_port dbg_checker
  #(.TRACE_PRESENT(TRACE_PRESENT)) chk_u (.clk, .rst, .cpu_sel,
  .cpu_write, .cpu_supervisor, .cpu_rdata, .trigger_enable,
  .cfg_action_halt, .resume, .debug_int_done, .irq_pending, .irq_level,
  .irq_critical_level, .core_trace_data, .halt_request,
  .debug_int_request, .irq_allowed, .processor_status, .debug_data_trace,
  .trace_clock_out, .combined_status_halt);

`default_nettype wire
